// ### include/lift_qs_defines.svh
// Purpose: timing counts, fault codes and serial bit positions for the quick-start sequencer
// Assumes: clk_sys at 50 MHz
// Notes: counts derive from times in their own units
`ifndef LIFT_QS_DEFINES_SVH
`define LIFT_QS_DEFINES_SVH

`define CLK_MHZ 50
`define HOLD_LIMIT_S 20
`define HOLD_LIMIT_CYC (`HOLD_LIMIT_S * 1000000 * `CLK_MHZ)
`define SPEED_DEADLINE_MS 150
`define SPEED_DEADLINE_CYC (`SPEED_DEADLINE_MS * 1000 * `CLK_MHZ)
`define CREEP_LIMIT_MM 16'sh0007
`define LEVEL_SLOW_MM 16'h0064
`define DIST_W 16
`define CNT_W 32
// fault codes
`define FLT_NONE 2'h0
`define FLT_TIMEOUT 2'h1
`define FLT_IN_TRAVEL 2'h2
`define FLT_CREEP 2'h3
// serial command bit positions
`define CMD_ZERO_RPM 0
`define CMD_INTERMEDIATE 1
`define CMD_FAST 2
`define CMD_TRAVEL 3
`define CMD_OFF_SWITCH 4
`define CMD_TRAVEL_SPEED 5
`define CMD_DIRECTION 6
`define CMD_W 7
// serial status bit positions
`define STAT_TRAVEL_ACTIVE 0
`define STAT_BRAKE 1
`define STAT_W 2
// register map
`define REG_STATUS 4'h0
`define REG_MASK 4'h1
`define REG_STATE 4'h2

`endif

// ### include/lift_qs_pkg.sv
// Purpose: shared types of the quick-start sequencer
// Assumes: nothing
// Notes: states are gray along idle-hold-travel path
package lift_qs_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_HOLD = 3'h1,
        ST_TRAVEL = 3'h3,
        ST_READJ = 3'h2,
        ST_FAULT = 3'h6
    } drive_state_t;
    typedef enum logic [2:0] {
        SPD_ZERO = 3'h0,
        SPD_POSITION = 3'h1,
        SPD_INTERMEDIATE = 3'h2,
        SPD_HIGH = 3'h3,
        SPD_READJ = 3'h4,
        SPD_LEVEL_SLOW = 3'h5
    } speed_sel_t;
endpackage : lift_qs_pkg

// ### include/lift_link_if.sv
// Purpose: discrete and serial signals between lift control and drive
// Assumes: one clock domain
// Notes: serial frame is modelled as parallel command and status words
`timescale 1ns/1ps
`default_nettype none
`include "lift_qs_defines.svh"
interface lift_link_if;
    logic controller_enable_in;
    logic direction_up_in;
    logic direction_down_in;
    logic hold_zero_in;
    logic positioning_speed_in;
    logic intermediate_speed_in;
    logic high_speed_in;
    logic readjust_speed_in;
    logic serial_mode;
    logic [`CMD_W-1:0] cmd_bits;
    logic [`DIST_W-1:0] residual_distance;
    logic controller_ready_out;
    logic brake_release_out;
    logic [`STAT_W-1:0] stat_bits;
    logic safe_torque_off_inputs;
    modport drive (
        input controller_enable_in, direction_up_in, direction_down_in, hold_zero_in,
        input positioning_speed_in, intermediate_speed_in, high_speed_in, readjust_speed_in,
        input serial_mode, cmd_bits, residual_distance, safe_torque_off_inputs,
        output controller_ready_out, brake_release_out, stat_bits
    );
    modport control (
        output controller_enable_in, direction_up_in, direction_down_in, hold_zero_in,
        output positioning_speed_in, intermediate_speed_in, high_speed_in, readjust_speed_in,
        output serial_mode, cmd_bits, residual_distance, safe_torque_off_inputs,
        input controller_ready_out, brake_release_out, stat_bits
    );
endinterface : lift_link_if
`default_nettype wire

// ### verilog/lift_drive_sequencer.sv
// Purpose: drive end: quick-start hold, brake/ready outputs, faults, speed priority
// Assumes: inputs synchronous to clk_sys; motor travel in signed mm from encoder
// Notes: speed selection only; ramps and current control are elsewhere
`timescale 1ns/1ps
`default_nettype none
`include "lift_qs_defines.svh"
module lift_drive_sequencer #(
    parameter logic [`CNT_W-1:0] HOLD_LIMIT = `HOLD_LIMIT_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // link to lift control
    lift_link_if.drive link,
    // drive internals
    input wire logic door_closing_in,
    input wire logic signed [`DIST_W-1:0] motor_travel_mm,
    input wire logic position_mode_in,
    input wire logic absolute_feedback_in,
    input wire logic leveling_approach_setting,
    input wire logic fault_clear,
    output logic [2:0] speed_select,
    output logic direct_leveling_active,
    output logic encoder_supervision_start,
    output logic [1:0] fault_code,
    // status registers
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////////
    // merge discrete and serial commands
    wire logic ser = link.serial_mode;
    wire logic zero_req = ser ? link.cmd_bits[`CMD_ZERO_RPM] : link.hold_zero_in;
    wire logic dir_req = ser ? link.cmd_bits[`CMD_TRAVEL] :
        (link.direction_up_in | link.direction_down_in);
    wire logic en_req = ser ? link.cmd_bits[`CMD_OFF_SWITCH] : link.controller_enable_in;
    wire logic speed_any = ser ?
        (link.cmd_bits[`CMD_TRAVEL_SPEED] &
         (link.cmd_bits[`CMD_INTERMEDIATE] | link.cmd_bits[`CMD_FAST])) :
        (link.positioning_speed_in | link.intermediate_speed_in | link.high_speed_in);
    wire logic readj_ok = en_req & link.readjust_speed_in & dir_req;
    wire logic level_ok = ser & position_mode_in & absolute_feedback_in;
    wire logic creep_bad = (motor_travel_mm > `CREEP_LIMIT_MM) ||
        (motor_travel_mm < -`CREEP_LIMIT_MM);

    lift_qs_pkg::drive_state_t state_reg, state_next;
    logic [`CNT_W-1:0] hold_cnt_reg;
    logic [1:0] fault_reg;
    logic [2:0] sts_reg;
    logic [2:0] mask_reg;

    wire logic hold_timeout = (state_reg == lift_qs_pkg::ST_HOLD) && (hold_cnt_reg >= HOLD_LIMIT);
    wire logic in_travel_err = (state_reg == lift_qs_pkg::ST_TRAVEL) && zero_req;
    wire logic creep_err = (state_reg == lift_qs_pkg::ST_HOLD) && creep_bad;
    wire logic any_err = hold_timeout | in_travel_err | creep_err;

    ////////////////////////////////////////////////////////////////////////////
    // sequence
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            lift_qs_pkg::ST_IDLE: begin
                if (readj_ok) state_next = lift_qs_pkg::ST_READJ;
                else if (en_req & dir_req & zero_req & door_closing_in)
                    state_next = lift_qs_pkg::ST_HOLD;
                else if (en_req & dir_req & speed_any) state_next = lift_qs_pkg::ST_TRAVEL;
            end
            lift_qs_pkg::ST_HOLD: begin
                if (any_err) state_next = lift_qs_pkg::ST_FAULT;
                else if (!en_req | !dir_req) state_next = lift_qs_pkg::ST_IDLE;
                else if (!zero_req) state_next = lift_qs_pkg::ST_TRAVEL;
            end
            lift_qs_pkg::ST_TRAVEL: begin
                if (any_err) state_next = lift_qs_pkg::ST_FAULT;
                else if (readj_ok) state_next = lift_qs_pkg::ST_READJ;
                else if (!en_req | !dir_req) state_next = lift_qs_pkg::ST_IDLE;
            end
            lift_qs_pkg::ST_READJ: begin
                if (!readj_ok) state_next = lift_qs_pkg::ST_IDLE;
            end
            lift_qs_pkg::ST_FAULT: begin
                if (fault_clear) state_next = lift_qs_pkg::ST_IDLE;
            end
            default: state_next = lift_qs_pkg::ST_IDLE;
        endcase
    end

    wire logic [1:0] fault_new = hold_timeout ? `FLT_TIMEOUT :
        in_travel_err ? `FLT_IN_TRAVEL : creep_err ? `FLT_CREEP : `FLT_NONE;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_reg <= lift_qs_pkg::ST_IDLE;
            hold_cnt_reg <= '0;
            fault_reg <= `FLT_NONE;
        end else begin
            state_reg <= state_next;
            hold_cnt_reg <= (state_reg == lift_qs_pkg::ST_HOLD) ? hold_cnt_reg + 1'b1 : '0;
            if (state_reg != lift_qs_pkg::ST_FAULT && any_err) fault_reg <= fault_new;
            else if (state_reg == lift_qs_pkg::ST_FAULT && fault_clear) fault_reg <= `FLT_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs and speed selection
    wire logic run = (state_reg == lift_qs_pkg::ST_HOLD) ||
        (state_reg == lift_qs_pkg::ST_TRAVEL) || (state_reg == lift_qs_pkg::ST_READJ);
    // brake opens in the same cycle as ready while safe_torque_off_inputs is set; energizing is the ready output itself
    wire logic brake_on = run & link.safe_torque_off_inputs;
    logic [2:0] spd_next;
    logic ready_reg, brake_reg, lvl_reg, sup_reg;
    logic [2:0] spd_reg;

    // slowing starts early only when the approach setting asks for it
    wire logic near_stop = link.residual_distance < `LEVEL_SLOW_MM;
    always_comb begin
        spd_next = lift_qs_pkg::SPD_ZERO;
        if (state_reg == lift_qs_pkg::ST_READJ) spd_next = lift_qs_pkg::SPD_READJ;
        else if (state_reg == lift_qs_pkg::ST_TRAVEL) begin
            if (level_ok && leveling_approach_setting && near_stop)
                spd_next = lift_qs_pkg::SPD_LEVEL_SLOW;
            else if (ser ? link.cmd_bits[`CMD_FAST] : link.high_speed_in)
                spd_next = lift_qs_pkg::SPD_HIGH;
            else if (ser ? link.cmd_bits[`CMD_INTERMEDIATE] : link.intermediate_speed_in)
                spd_next = lift_qs_pkg::SPD_INTERMEDIATE;
            else spd_next = lift_qs_pkg::SPD_POSITION;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ready_reg <= 1'b0;
            brake_reg <= 1'b0;
            spd_reg <= 3'h0;
            lvl_reg <= 1'b0;
            sup_reg <= 1'b0;
        end else begin
            ready_reg <= run & (state_next != lift_qs_pkg::ST_FAULT);
            brake_reg <= brake_on & (state_next != lift_qs_pkg::ST_FAULT);
            spd_reg <= spd_next;
            lvl_reg <= level_ok & (state_reg == lift_qs_pkg::ST_TRAVEL);
            sup_reg <= ~zero_req & (state_reg == lift_qs_pkg::ST_HOLD);
        end
    end

    assign link.controller_ready_out = ready_reg;
    assign link.brake_release_out = brake_reg;
    assign link.stat_bits[`STAT_TRAVEL_ACTIVE] = ready_reg;
    assign link.stat_bits[`STAT_BRAKE] = brake_reg;
    assign speed_select = spd_reg;
    assign direct_leveling_active = lvl_reg;
    assign encoder_supervision_start = sup_reg;
    assign fault_code = fault_reg;

    ////////////////////////////////////////////////////////////////////////////
    // status/mask registers: bit0 timeout, bit1 in-travel, bit2 creep
    wire logic [2:0] evt = {creep_err, in_travel_err, hold_timeout} &
        {3{state_reg != lift_qs_pkg::ST_FAULT}};
    wire logic wr_sts = reg_wr && (reg_addr == `REG_STATUS);
    wire logic wr_msk = reg_wr && (reg_addr == `REG_MASK);
    wire logic [31:0] rd_mux = (reg_addr == `REG_STATUS) ? {29'h0, sts_reg} :
        (reg_addr == `REG_MASK) ? {29'h0, mask_reg} :
        (reg_addr == `REG_STATE) ? {27'h0, fault_reg, state_reg} : 32'h0;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sts_reg <= 3'h0;
            mask_reg <= 3'h0;
            reg_rdata <= 32'h0;
        end else begin
            // set wins over a simultaneous write-one clear
            sts_reg <= (sts_reg & ~(wr_sts ? reg_wdata[2:0] : 3'h0)) | evt;
            if (wr_msk) mask_reg <= reg_wdata[2:0];
            reg_rdata <= reg_rd ? rd_mux : 32'h0;
        end
    end
    assign irq = |(sts_reg & ~mask_reg);
endmodule : lift_drive_sequencer
`default_nettype wire

// ### verilog/lift_control_end.sv
// Purpose: lift control end: drives quick-start and travel requests to the drive
// Assumes: inputs synchronous to clk_sys
// Notes: serial sequences hold, then speed bits, then drops hold; discrete drops hold before setting speed bits
`timescale 1ns/1ps
`default_nettype none
`include "lift_qs_defines.svh"
module lift_control_end #(
    parameter logic [`CNT_W-1:0] SPEED_DEADLINE = `SPEED_DEADLINE_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // link to drive
    lift_link_if.control link,
    // user side
    input wire logic use_serial,
    input wire logic door_closing,
    input wire logic door_closed,
    input wire logic dir_up,
    input wire logic [1:0] speed_req,
    input wire logic readjust_req,
    input wire logic rope_settled,
    input wire logic [`DIST_W-1:0] remaining_mm,
    output logic busy
);
    typedef enum logic [1:0] {C_IDLE = 2'h0, C_HOLD = 2'h1, C_SPEED = 2'h3, C_RUN = 2'h2} ctl_t;
    ctl_t st_reg;
    logic hold_reg, spd_reg, en_reg, adj_reg;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_reg <= C_IDLE;
            hold_reg <= 1'b0;
            spd_reg <= 1'b0;
            en_reg <= 1'b0;
            adj_reg <= 1'b0;
        end else begin
            adj_reg <= readjust_req & rope_settled;
            unique case (st_reg)
                C_IDLE: if (door_closing) begin
                    st_reg <= C_HOLD;
                    en_reg <= 1'b1;
                    hold_reg <= 1'b1;
                end
                // serial sets speed bits first; discrete drops the hold first
                C_HOLD: if (door_closed) begin
                    st_reg <= C_SPEED;
                    spd_reg <= use_serial;
                    hold_reg <= use_serial;
                end
                C_SPEED: begin
                    hold_reg <= 1'b0;
                    spd_reg <= 1'b1;
                    st_reg <= C_RUN;
                end
                C_RUN: if (!door_closed) begin
                    st_reg <= C_IDLE;
                    en_reg <= 1'b0;
                    spd_reg <= 1'b0;
                end
            endcase
        end
    end

    assign busy = st_reg != C_IDLE;
    assign link.serial_mode = use_serial;
    assign link.controller_enable_in = en_reg;
    assign link.direction_up_in = en_reg & dir_up;
    assign link.direction_down_in = en_reg & ~dir_up;
    assign link.hold_zero_in = hold_reg;
    assign link.positioning_speed_in = spd_reg && speed_req == 2'h0;
    assign link.intermediate_speed_in = spd_reg && speed_req == 2'h1;
    assign link.high_speed_in = spd_reg && speed_req[1];
    assign link.readjust_speed_in = adj_reg;
    assign link.safe_torque_off_inputs = en_reg;
    assign link.residual_distance = remaining_mm;
    assign link.cmd_bits[`CMD_ZERO_RPM] = hold_reg;
    assign link.cmd_bits[`CMD_INTERMEDIATE] = spd_reg & ~speed_req[1];
    assign link.cmd_bits[`CMD_FAST] = spd_reg & speed_req[1];
    assign link.cmd_bits[`CMD_TRAVEL] = en_reg;
    assign link.cmd_bits[`CMD_OFF_SWITCH] = en_reg;
    assign link.cmd_bits[`CMD_TRAVEL_SPEED] = spd_reg;
    assign link.cmd_bits[`CMD_DIRECTION] = en_reg & ~dir_up;
endmodule : lift_control_end
`default_nettype wire

// ### sim/lift_qs_asserts.sv
// Purpose: link checks between the two ends
// Assumes: one clock, srst synchronous active high
// Notes: door and rope rules are checked in the bench
`timescale 1ns/1ps
`default_nettype none
`include "lift_qs_defines.svh"
module lift_qs_asserts #(
    parameter int SPEED_DL = 20
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // control to drive
    input wire logic controller_enable_in,
    input wire logic hold_zero_in,
    input wire logic positioning_speed_in,
    input wire logic intermediate_speed_in,
    input wire logic high_speed_in,
    input wire logic serial_mode,
    input wire logic [`CMD_W-1:0] cmd_bits,
    input wire logic safe_torque_off_inputs,
    // drive to control
    input wire logic controller_ready_out,
    input wire logic brake_release_out,
    input wire logic [`STAT_W-1:0] stat_bits
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////////////
    // serial speed request as a plain signal for $past
    wire logic speed_bits_set = cmd_bits[`CMD_TRAVEL_SPEED]
        && (cmd_bits[`CMD_FAST] || cmd_bits[`CMD_INTERMEDIATE]);
    sequence hold_left_s;
        $fell(hold_zero_in) && controller_enable_in && !serial_mode;
    endsequence
    sequence speed_given_s;
        positioning_speed_in || intermediate_speed_in || high_speed_in;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    brake_needs_ready_a: assert property (
        brake_release_out |-> controller_ready_out)
        else $error("brake open without ready");
    ready_needs_enable_a: assert property (
        $rose(controller_ready_out) |-> $past(controller_enable_in))
        else $error("ready rose without enable");
    ready_needs_power_a: assert property (
        $rose(controller_ready_out) |-> $past(safe_torque_off_inputs))
        else $error("ready rose without torque path");
    power_on_hold_a: assert property (
        $rose(hold_zero_in) |-> ##[0:1] safe_torque_off_inputs)
        else $error("torque path late at hold request");
    speed_after_hold_a: assert property (
        hold_zero_in && !serial_mode |->
        !(positioning_speed_in || intermediate_speed_in || high_speed_in))
        else $error("speed applied during hold");
    speed_deadline_a: assert property (
        hold_left_s |-> ##[0:SPEED_DL] speed_given_s)
        else $error("no travel speed after hold release");
    serial_leave_order_a: assert property (
        serial_mode && cmd_bits[`CMD_TRAVEL] && $fell(cmd_bits[`CMD_ZERO_RPM])
        |-> $past(speed_bits_set))
        else $error("zero bit cleared before speed bits");
    brake_status_travel_a: assert property (
        stat_bits[`STAT_BRAKE] |-> stat_bits[`STAT_TRAVEL_ACTIVE])
        else $error("brake status without travel active");
endmodule : lift_qs_asserts
`default_nettype wire

// ### sim/tb_lift_drive_quickstart_sequencer.sv
// Purpose: both ends joined for ordinary trips, a second drive end fed by hand for faults
// Assumes: hold limit shortened to 100 cycles, speed deadline to 20
// Notes: each trip row starts from reset so a trip never has to be ended
`timescale 1ns/1ps
`default_nettype none
`include "lift_qs_defines.svh"
module tb_lift_drive_quickstart_sequencer;
    typedef struct packed {
        logic ser;
        logic up;
        logic [1:0] spd;
        logic rdj;
        logic [2:0] exp;
    } row_t;
    logic clk_sys, srst, use_serial, door_closing, door_closed, dir_up, readjust_req;
    logic rope_settled, door2, position_mode, abs_fb, approach_slow, fault_clear;
    logic reg_wr, reg_rd, enc_seen, lvl1, lvl2, enc1, enc2, irq1, irq2, busy;
    logic [1:0] speed_req, flt1, flt2;
    logic signed [15:0] motor_mm;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, rdata1, rdata2, d;
    logic [2:0] sel1, sel2;
    int fail_count, n_tests, cyc;
    row_t rows[6];
    lift_link_if link1();
    lift_link_if link2();
    ////////////////////////////////////////////////////////////////////////////////
    lift_control_end #(.SPEED_DEADLINE(32'h14)) lift_control_end_inst (.clk_sys(clk_sys),
        .srst(srst), .link(link1), .use_serial(use_serial), .door_closing(door_closing),
        .door_closed(door_closed), .dir_up(dir_up), .speed_req(speed_req),
        .readjust_req(readjust_req), .rope_settled(rope_settled), .remaining_mm(16'h0FFF),
        .busy(busy));
    lift_drive_sequencer #(.HOLD_LIMIT(32'h64)) lift_drive_sequencer_inst (.clk_sys(clk_sys),
        .srst(srst), .link(link1), .door_closing_in(door_closing), .motor_travel_mm(motor_mm),
        .position_mode_in(position_mode), .absolute_feedback_in(abs_fb),
        .leveling_approach_setting(approach_slow), .fault_clear(fault_clear),
        .speed_select(sel1), .direct_leveling_active(lvl1), .encoder_supervision_start(enc1),
        .fault_code(flt1), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(rdata1), .irq(irq1));
    // second drive end, fed by hand to break the control rules
    lift_drive_sequencer #(.HOLD_LIMIT(32'h64)) lift_drive_sequencer_inst_b (.clk_sys(clk_sys),
        .srst(srst), .link(link2), .door_closing_in(door2), .motor_travel_mm(motor_mm),
        .position_mode_in(position_mode), .absolute_feedback_in(abs_fb),
        .leveling_approach_setting(approach_slow), .fault_clear(fault_clear),
        .speed_select(sel2), .direct_leveling_active(lvl2), .encoder_supervision_start(enc2),
        .fault_code(flt2), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(rdata2), .irq(irq2));
    lift_qs_asserts #(.SPEED_DL(20)) lift_qs_asserts_inst (.clk_sys(clk_sys), .srst(srst),
        .controller_enable_in(link1.controller_enable_in), .hold_zero_in(link1.hold_zero_in),
        .positioning_speed_in(link1.positioning_speed_in),
        .intermediate_speed_in(link1.intermediate_speed_in),
        .high_speed_in(link1.high_speed_in), .serial_mode(link1.serial_mode),
        .cmd_bits(link1.cmd_bits), .safe_torque_off_inputs(link1.safe_torque_off_inputs),
        .controller_ready_out(link1.controller_ready_out),
        .brake_release_out(link1.brake_release_out), .stat_bits(link1.stat_bits));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'h0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (enc1 === 1'h1) enc_seen <= 1'h1;
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            fail_count = fail_count + 1;
            complete_run();
        end
    end
    task automatic check_bit(input string name, input logic exp, input logic got);
        check_word(name, {31'h0, exp}, {31'h0, got});
    endtask : check_bit
    task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check_word
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : wait_cyc
    task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'h1;
        @(posedge clk_sys);
        reg_wr <= 1'h0;
    endtask : reg_write
    task automatic reg_read(input logic [3:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        #1;
        d = rdata2;
    endtask : reg_read
    task automatic do_reset();
        @(posedge clk_sys);
        srst <= 1'h1;
        door_closing <= 1'h0;
        door_closed <= 1'h0;
        repeat (10) @(posedge clk_sys);
        srst <= 1'h0;
        repeat (2) @(posedge clk_sys);
    endtask : do_reset
    task automatic clear2();
        @(posedge clk_sys);
        {link2.controller_enable_in, link2.direction_up_in, link2.direction_down_in,
            link2.hold_zero_in, link2.positioning_speed_in, link2.intermediate_speed_in,
            link2.high_speed_in, link2.readjust_speed_in, link2.serial_mode,
            link2.safe_torque_off_inputs, link2.cmd_bits, link2.residual_distance, door2,
            approach_slow, abs_fb, motor_mm} <= '0;
        fault_clear <= 1'h1;
        @(posedge clk_sys);
        fault_clear <= 1'h0;
    endtask : clear2
    task automatic hold2();
        @(posedge clk_sys);
        {link2.controller_enable_in, link2.direction_up_in, link2.hold_zero_in,
            link2.safe_torque_off_inputs, door2} <= 5'h1F;
    endtask : hold2
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {srst, use_serial, door_closing, door_closed, dir_up, readjust_req, rope_settled, door2,
            position_mode, abs_fb, approach_slow, fault_clear, reg_wr, reg_rd} = '0;
        {speed_req, reg_addr, reg_wdata, motor_mm, enc_seen, fail_count, n_tests, cyc} = '0;
        rows[0] = '{1'h0, 1'h1, 2'h0, 1'h0, lift_qs_pkg::SPD_POSITION};
        rows[1] = '{1'h0, 1'h0, 2'h1, 1'h0, lift_qs_pkg::SPD_INTERMEDIATE};
        rows[2] = '{1'h0, 1'h1, 2'h2, 1'h0, lift_qs_pkg::SPD_HIGH};
        rows[3] = '{1'h1, 1'h1, 2'h3, 1'h0, lift_qs_pkg::SPD_HIGH};
        rows[4] = '{1'h1, 1'h0, 2'h1, 1'h0, lift_qs_pkg::SPD_INTERMEDIATE};
        rows[5] = '{1'h0, 1'h1, 2'h2, 1'h1, lift_qs_pkg::SPD_READJ};
        foreach (rows[i]) begin
            do_reset();
            enc_seen = 1'h0;
            @(posedge clk_sys);
            use_serial <= rows[i].ser;
            dir_up <= rows[i].up;
            speed_req <= rows[i].spd;
            door_closing <= 1'h1;
            for (int k = 0; k < 20 && link1.controller_ready_out !== 1'h1; k++) wait_cyc(1);
            check_bit("ready", 1'h1, link1.controller_ready_out);
            check_bit("brake", 1'h1, link1.brake_release_out);
            check_word("hold speed", lift_qs_pkg::SPD_ZERO, sel1);
            if (rows[i].ser) check_word("status bits", 32'h3, link1.stat_bits);
            check_bit("encoder early", 1'h0, enc_seen);
            @(posedge clk_sys);
            door_closed <= 1'h1;
            readjust_req <= rows[i].rdj;
            rope_settled <= rows[i].rdj;
            wait_cyc(25);
            check_bit("encoder start", 1'h1, enc_seen);
            check_word("travel speed", rows[i].exp, sel1);
            check_word("no fault", `FLT_NONE, flt1);
        end
        clear2();
        do_reset();
        reg_read(4'h0);
        check_word("status reset", 32'h0, d);
        reg_read(4'hF);
        check_word("unmapped", 32'h0, d);
        // creep at exactly the limit is allowed, one mm beyond it faults
        hold2();
        wait_cyc(4);
        check_bit("ready b", 1'h1, link2.controller_ready_out);
        @(posedge clk_sys);
        motor_mm <= 16'sh0007;
        wait_cyc(3);
        check_word("creep limit", `FLT_NONE, flt2);
        @(posedge clk_sys);
        motor_mm <= -16'sh0008;
        wait_cyc(3);
        check_word("creep fault", `FLT_CREEP, flt2);
        check_bit("fault ready", 1'h0, link2.controller_ready_out);
        check_bit("fault brake", 1'h0, link2.brake_release_out);
        reg_read(4'h0);
        check_word("creep status", 32'h4, {29'h0, d[2:0]});
        clear2();
        reg_write(4'h0, 32'h4);
        reg_read(4'h0);
        check_word("status cleared", 32'h0, {29'h0, d[2:0]});
        // hold limit of 100 cycles
        hold2();
        wait_cyc(90);
        check_word("hold short", `FLT_NONE, flt2);
        wait_cyc(20);
        check_word("hold timeout", `FLT_TIMEOUT, flt2);
        clear2();
        wait_cyc(2);
        check_word("fault cleared", `FLT_NONE, flt2);
        reg_write(4'h1, 32'h7);
        wait_cyc(1);
        check_bit("irq masked", 1'h0, irq2);
        reg_write(4'h1, 32'h0);
        wait_cyc(1);
        check_bit("irq raised", 1'h1, irq2);
        reg_write(4'h0, 32'h1);
        wait_cyc(1);
        check_bit("irq cleared", 1'h0, irq2);
        // hold requested while a trip runs
        @(posedge clk_sys);
        {link2.controller_enable_in, link2.direction_up_in, link2.high_speed_in,
            link2.safe_torque_off_inputs} <= 4'hF;
        wait_cyc(5);
        @(posedge clk_sys);
        link2.hold_zero_in <= 1'h1;
        wait_cyc(3);
        check_word("hold in travel", `FLT_IN_TRAVEL, flt2);
        clear2();
        // readjustment needs a direction and then beats the high speed request
        @(posedge clk_sys);
        {link2.controller_enable_in, link2.readjust_speed_in, link2.high_speed_in,
            link2.safe_torque_off_inputs} <= 4'hF;
        wait_cyc(4);
        check_bit("readjust no dir", 1'h0, sel2 === lift_qs_pkg::SPD_READJ);
        @(posedge clk_sys);
        link2.direction_up_in <= 1'h1;
        wait_cyc(4);
        check_word("readjust", lift_qs_pkg::SPD_READJ, sel2);
        clear2();
        // direct leveling over the serial link, fast travel, 50 mm to go
        @(posedge clk_sys);
        link2.serial_mode <= 1'h1;
        link2.cmd_bits <= 7'h7C;
        link2.safe_torque_off_inputs <= 1'h1;
        link2.residual_distance <= 16'h0032;
        position_mode <= 1'h1;
        wait_cyc(4);
        check_bit("level no abs", 1'h0, lvl2);
        @(posedge clk_sys);
        abs_fb <= 1'h1;
        wait_cyc(4);
        check_bit("level allowed", 1'h1, lvl2);
        @(posedge clk_sys);
        approach_slow <= 1'h1;
        wait_cyc(3);
        check_word("slow approach", lift_qs_pkg::SPD_LEVEL_SLOW, sel2);
        clear2();
        complete_run();
    end
endmodule : tb_lift_drive_quickstart_sequencer
`default_nettype wire
